/* File: design/sdsp_core.sv */
/*
 * Serial port master: data window onto transmit and receive FIFOs,
 * status flags, even prescaler and optional receive input delay.
 * Assumes a simple register port (read data one cycle after strobe),
 * one 50 MHz clock and a peer that answers in clock mode 0.
 */
`timescale 1ns/1ps

// Behaviour
// - Delay bit set adds two clock cycles on the receive data path.
// - Reading data register returns and removes oldest receive FIFO word.
// - Writing data register pushes the word into the transmit FIFO.
// - Status bit 0 is one while transmit FIFO is empty; resets one.
// - Status bit 1 is one while transmit FIFO has space; resets one.
// - Status bit 2 is one while receive FIFO holds data; resets zero.
// - Status bit 3 is one while receive FIFO is full; resets zero.
// - Status bit 4 is one while shifting or transmit FIFO not empty.
// - Bit rate is clock over divisor times one plus clock rate field.
module sdsp_core
    import sdsp_pkg::*;
#(
    parameter int FIFO_DEPTH = sdsp_pkg::SDSP_FIFO_DEPTH
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic [7:0] regAddr,
    input wire logic [31:0] regWdata,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [31:0] regRdata,
    output logic spiSclk,
    output logic spiMosi,
    output logic spiCsN,
    input wire logic spiMiso
);
    import sdsp_pkg::*;

    // ****************************************************************
    // FIFOs
    // ****************************************************************
    // Depth is a parameter so that tests can fill both FIFOs quickly;
    // both answer status in the same cycle as the pointer update.
    sdsp_fifo_if #(.WIDTH(SDSP_DATA_W)) txBus ();
    sdsp_fifo_if #(.WIDTH(SDSP_DATA_W)) rxBus ();

    sdsp_fifo #(
        .WIDTH(SDSP_DATA_W),
        .DEPTH(FIFO_DEPTH)
    ) txFifo (
        .core_clk(core_clk),
        .reset(reset),
        .port(txBus)
    );

    sdsp_fifo #(
        .WIDTH(SDSP_DATA_W),
        .DEPTH(FIFO_DEPTH)
    ) rxFifo (
        .core_clk(core_clk),
        .reset(reset),
        .port(rxBus)
    );

    // ****************************************************************
    // Register file
    // ****************************************************************
    logic [4:0] frameSize;
    logic [7:0] serialClockRate;
    logic portEnable;
    logic inputSampleDelay;
    logic [7:0] prescaleDivisor;

    wire selCtrl0 = (regAddr == SDSP_OFF_CTRL0);
    wire selCtrl1 = (regAddr == SDSP_OFF_CTRL1);
    wire selData = (regAddr == SDSP_OFF_DATA);
    wire selStatus = (regAddr == SDSP_OFF_STATUS);
    wire selPrescale = (regAddr == SDSP_OFF_PRESCALE);

    // Full FIFO drops the write; software polls the space flag first
    assign txBus.wrValid = regWrite && selData;
    assign txBus.wrData = regWdata;
    assign rxBus.rdReady = regRead && selData;

    // Configuration should change only while the port is idle; a
    // mid-frame divisor or rate write changes the half bit being counted.
    always_ff @(posedge core_clk) begin
        if (reset) begin
            frameSize <= SDSP_RST_FRAME_SIZE;
            serialClockRate <= SDSP_RST_SCR;
            portEnable <= SDSP_RST_ENABLE;
            inputSampleDelay <= SDSP_RST_DELAY;
            prescaleDivisor <= SDSP_RST_PRESCALE;
        end else if (regWrite) begin
            if (selCtrl0) begin
                frameSize <= regWdata[SDSP_CTRL0_SIZE_MSB:SDSP_CTRL0_SIZE_LSB];
                serialClockRate <= regWdata[SDSP_CTRL0_SCR_MSB:SDSP_CTRL0_SCR_LSB];
            end
            if (selCtrl1) begin
                portEnable <= regWdata[SDSP_CTRL1_ENABLE];
                inputSampleDelay <= regWdata[SDSP_CTRL1_DELAY];
            end
            if (selPrescale) begin
                prescaleDivisor <= regWdata[7:0];
            end
        end
    end

    // ****************************************************************
    // Status word
    // ****************************************************************
    sdsp_state_e state;
    logic [31:0] statusWord;
    logic [31:0] ctrl0Word;
    logic [31:0] ctrl1Word;

    // Also covers words still waiting in the transmit FIFO
    wire portActive = (state != SDSP_IDLE) || txBus.rdValid;

    always_comb begin
        statusWord = '0;
        statusWord[SDSP_ST_TX_EMPTY] = !txBus.rdValid;
        statusWord[SDSP_ST_TX_SPACE] = txBus.wrReady;
        statusWord[SDSP_ST_RX_DATA] = rxBus.rdValid;
        statusWord[SDSP_ST_RX_FULL] = !rxBus.wrReady;
        statusWord[SDSP_ST_ACTIVE] = portActive;
        ctrl0Word = '0;
        ctrl0Word[SDSP_CTRL0_SIZE_MSB:SDSP_CTRL0_SIZE_LSB] = frameSize;
        ctrl0Word[SDSP_CTRL0_SCR_MSB:SDSP_CTRL0_SCR_LSB] = serialClockRate;
        ctrl1Word = '0;
        ctrl1Word[SDSP_CTRL1_ENABLE] = portEnable;
        ctrl1Word[SDSP_CTRL1_DELAY] = inputSampleDelay;
    end

    // ****************************************************************
    // Read path
    // ****************************************************************
    // Register data is captured at the strobe; FIFO data is already
    // registered inside the FIFO at the pop, so it is muxed afterwards.
    // Unmapped addresses read as zero.
    logic readPending;
    logic readFromFifo;
    logic [31:0] readHold;

    wire [31:0] readMux =
        selCtrl0 ? ctrl0Word :
        selCtrl1 ? ctrl1Word :
        selStatus ? statusWord :
        selPrescale ? {24'h000000, prescaleDivisor} :
        32'h00000000;

    always_ff @(posedge core_clk) begin
        if (reset) begin
            readPending <= 1'b0;
            readFromFifo <= 1'b0;
            readHold <= '0;
        end else begin
            readPending <= regRead;
            readFromFifo <= regRead && selData;
            readHold <= regRead ? readMux : 32'h00000000;
        end
    end

    assign regRdata = !readPending ? 32'h00000000 :
                      readFromFifo ? rxBus.rdData : readHold;

    // ****************************************************************
    // Receive input: synchroniser, filter, optional delay
    // ****************************************************************
    // Three flops plus the agreement filter cost four cycles, six with
    // the delay bit; a half period no longer than that makes the sample
    // point see the previous bit.
    logic misoMeta;
    logic misoSync;
    logic misoLate;
    logic misoClean;
    logic [SDSP_DELAY_STAGES-1:0] misoDelay;

    always_ff @(posedge core_clk) begin
        if (reset) begin
            misoMeta <= 1'b0;
            misoSync <= 1'b0;
            misoLate <= 1'b0;
            misoClean <= 1'b0;
        end else begin
            misoMeta <= spiMiso;
            misoSync <= misoMeta;
            misoLate <= misoSync;
            if (misoSync == misoLate) begin
                misoClean <= misoLate;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            misoDelay <= '0;
        end else begin
            misoDelay <= {misoDelay[SDSP_DELAY_STAGES-2:0], misoClean};
        end
    end

    wire sampleBit = inputSampleDelay ?
                     misoDelay[SDSP_DELAY_STAGES-1] : misoClean;

    // ****************************************************************
    // Bit clock timing
    // ****************************************************************
    // Divisor is even, so each half bit is divisor/2 * (1 + rate).
    // Zero divisor is out of range; it is clamped to the fastest rate.
    // Recomputed every cycle from the live registers.
    wire [15:0] halfRaw = 16'(prescaleDivisor[7:1])
                          * (16'(serialClockRate) + 16'h0001);
    wire [15:0] halfPeriod = (halfRaw == 16'h0000) ? 16'h0001 : halfRaw;

    logic [15:0] halfCount;
    wire halfDone = (halfCount == halfPeriod - 16'h0001);

    // ****************************************************************
    // Shifter
    // ****************************************************************
    logic [31:0] txWord;
    logic [31:0] rxShift;
    logic [4:0] bitIdx;
    sdsp_state_e next_state;

    // A frame starts only with receive space, so the push never drops
    wire startFrame = portEnable && txBus.rdValid && rxBus.wrReady;

    assign txBus.rdReady = (state == SDSP_IDLE) && startFrame;
    assign rxBus.wrValid = (state == SDSP_DONE);
    assign rxBus.wrData = rxShift;

    // A frame is frameSize+1 bits, MSB first; bitIdx counts bits left after the current one.
    always_comb begin
        next_state = state;
        case (state)
            SDSP_IDLE: begin
                if (startFrame) begin
                    next_state = SDSP_LOAD;
                end
            end
            SDSP_LOAD: begin
                next_state = SDSP_LOW;
            end
            SDSP_LOW: begin
                if (halfDone) begin
                    next_state = SDSP_HIGH;
                end
            end
            SDSP_HIGH: begin
                if (halfDone && bitIdx == 5'h00) begin
                    next_state = SDSP_DONE;
                end else if (halfDone) begin
                    next_state = SDSP_LOW;
                end
            end
            SDSP_DONE: begin
                next_state = SDSP_IDLE;
            end
            default: begin
                next_state = SDSP_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            state <= SDSP_IDLE;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            halfCount <= '0;
        end else if ((state == SDSP_LOW || state == SDSP_HIGH) && !halfDone) begin
            halfCount <= halfCount + 16'h0001;
        end else begin
            halfCount <= '0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            txWord <= '0;
            rxShift <= '0;
            bitIdx <= '0;
        end else if (state == SDSP_LOAD) begin
            txWord <= txBus.rdData;
            rxShift <= '0;
            bitIdx <= frameSize;
        end else if (state == SDSP_LOW && halfDone) begin
            rxShift <= {rxShift[30:0], sampleBit};
        end else if (state == SDSP_HIGH && halfDone && bitIdx != 5'h00) begin
            bitIdx <= bitIdx - 5'h01;
        end
    end

    // ****************************************************************
    // Pins
    // ****************************************************************
    // Data out moves with the falling serial clock, so the peer has a
    // full half period of setup before it samples on the rising one.
    always_ff @(posedge core_clk) begin
        if (reset) begin
            spiSclk <= 1'b0;
            spiCsN <= 1'b1;
            spiMosi <= 1'b0;
        end else begin
            case (state)
                SDSP_LOAD: begin
                    spiCsN <= 1'b0;
                    spiSclk <= 1'b0;
                    spiMosi <= txBus.rdData[frameSize];
                end
                SDSP_LOW: begin
                    if (halfDone) begin
                        spiSclk <= 1'b1;
                    end
                end
                SDSP_HIGH: begin
                    if (halfDone) begin
                        spiSclk <= 1'b0;
                        if (bitIdx != 5'h00) begin
                            spiMosi <= txWord[bitIdx - 5'h01];
                        end
                    end
                end
                SDSP_DONE: begin
                    spiCsN <= 1'b1;
                    spiMosi <= 1'b0;
                end
                default: begin
                    spiSclk <= 1'b0;
                end
            endcase
        end
    end

endmodule

/* File: design/sdsp_pkg.sv */
/*
 * Constants for the serial port data window, status and prescaler block.
 * Assumes a 32-bit register port with byte offsets and one 50 MHz clock.
 */
package sdsp_pkg;

    // ****************************************************************
    // Register offsets (byte addresses)
    // ****************************************************************
    localparam logic [7:0] SDSP_OFF_CTRL0 = 8'h00;
    localparam logic [7:0] SDSP_OFF_CTRL1 = 8'h04;
    localparam logic [7:0] SDSP_OFF_DATA = 8'h08;
    localparam logic [7:0] SDSP_OFF_STATUS = 8'h0C;
    localparam logic [7:0] SDSP_OFF_PRESCALE = 8'h10;

    // ****************************************************************
    // Field positions
    // ****************************************************************
    localparam int SDSP_CTRL0_SIZE_LSB = 0;
    localparam int SDSP_CTRL0_SIZE_MSB = 4;
    localparam int SDSP_CTRL0_SCR_LSB = 8;
    localparam int SDSP_CTRL0_SCR_MSB = 15;
    localparam int SDSP_CTRL1_ENABLE = 1;
    localparam int SDSP_CTRL1_DELAY = 21;
    localparam int SDSP_ST_TX_EMPTY = 0;
    localparam int SDSP_ST_TX_SPACE = 1;
    localparam int SDSP_ST_RX_DATA = 2;
    localparam int SDSP_ST_RX_FULL = 3;
    localparam int SDSP_ST_ACTIVE = 4;

    // ****************************************************************
    // Reset values
    // ****************************************************************
    localparam logic [4:0] SDSP_RST_FRAME_SIZE = 5'h07;
    localparam logic [7:0] SDSP_RST_SCR = 8'h00;
    localparam logic [7:0] SDSP_RST_PRESCALE = 8'h00;
    localparam logic SDSP_RST_ENABLE = 1'b0;
    localparam logic SDSP_RST_DELAY = 1'b0;

    // ****************************************************************
    // Sizes
    // ****************************************************************
    localparam int SDSP_DATA_W = 32;
    localparam int SDSP_FIFO_DEPTH = 32;
    localparam int SDSP_DELAY_STAGES = 2;

    typedef enum logic [2:0] {
        SDSP_IDLE = 3'b000,
        SDSP_LOAD = 3'b001,
        SDSP_LOW = 3'b010,
        SDSP_HIGH = 3'b011,
        SDSP_DONE = 3'b100
    } sdsp_state_e;

endpackage

/* File: design/sdsp_fifo_if.sv */
/*
 * Valid/ready carrier between the port logic and one FIFO.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/1ps
interface sdsp_fifo_if #(
    parameter int WIDTH = 32
) ();
    logic wrValid;
    logic wrReady;
    logic [WIDTH-1:0] wrData;
    logic rdValid;
    logic rdReady;
    logic [WIDTH-1:0] rdData;

    modport fill(output wrValid, output wrData, input wrReady);
    modport drain(output rdReady, input rdValid, input rdData);
    modport fifo(input wrValid, input wrData, input rdReady,
                 output wrReady, output rdValid, output rdData);
endinterface

/* File: design/sdsp_fifo.sv */
/*
 * Synchronous FIFO; read data is registered at the pop.
 * Assumes one clock and a synchronous active-high reset.
 */
`timescale 1ns/1ps
module sdsp_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 32
) (
    input wire logic core_clk,
    input wire logic reset,
    sdsp_fifo_if.fifo port
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL_COUNT = (AW+1)'(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wrPtr;
    logic [AW-1:0] rdPtr;
    logic [AW:0] count;
    logic [WIDTH-1:0] readWord;

    wire doWrite = port.wrValid && port.wrReady;
    wire doRead = port.rdReady && port.rdValid;

    assign port.wrReady = (count != FULL_COUNT);
    assign port.rdValid = (count != '0);
    assign port.rdData = readWord;

    always_ff @(posedge core_clk) begin
        if (doWrite) begin
            mem[wrPtr] <= port.wrData;
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            wrPtr <= '0;
            rdPtr <= '0;
            count <= '0;
            readWord <= '0;
        end else begin
            if (doWrite) begin
                wrPtr <= (wrPtr == AW'(DEPTH - 1)) ? '0 : wrPtr + 1'b1;
            end
            if (doRead) begin
                rdPtr <= (rdPtr == AW'(DEPTH - 1)) ? '0 : rdPtr + 1'b1;
                readWord <= mem[rdPtr];
            end
            if (doWrite && !doRead) begin
                count <= count + 1'b1;
            end else if (doRead && !doWrite) begin
                count <= count - 1'b1;
            end
        end
    end
endmodule

/* File: testbench/sdsp_core_monitor.sv */
/*
 * Port checker for the serial port core.
 * Assumes binding onto sdsp_core; config changes only while no frame runs.
 */
`timescale 1ns/1ps
module sdsp_core_monitor
    import sdsp_pkg::*;
#(
    parameter int FIFO_DEPTH = SDSP_FIFO_DEPTH
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic [7:0] regAddr,
    input wire logic [31:0] regWdata,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [31:0] regRdata,
    input wire logic spiSclk,
    input wire logic spiMosi,
    input wire logic spiCsN,
    input wire logic spiMiso
);
    logic [7:0] preShadow;
    logic [7:0] rateShadow;
    logic [16:0] halfExp;
    logic [16:0] lowCnt;
    logic [16:0] highCnt;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);

    // ****************************************************************
    // Expected half period, shadowed from register writes
    // ****************************************************************
    // Odd divisors fall back to their upper seven bits
    assign halfExp = (preShadow[7:1] == 7'h00) ? 17'h00001 :
                     17'(preShadow[7:1]) * (17'h00001 + 17'(rateShadow));

    always_ff @(posedge core_clk) begin
        if (reset) begin
            preShadow <= SDSP_RST_PRESCALE;
            rateShadow <= SDSP_RST_SCR;
        end else begin
            if (regWrite && regAddr == SDSP_OFF_PRESCALE) preShadow <= regWdata[7:0];
            if (regWrite && regAddr == SDSP_OFF_CTRL0) rateShadow <= regWdata[15:8];
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            lowCnt <= 17'h00000;
            highCnt <= 17'h00000;
        end else begin
            lowCnt <= (!spiCsN && !spiSclk) ? lowCnt + 17'h00001 : 17'h00000;
            highCnt <= spiSclk ? highCnt + 17'h00001 : 17'h00000;
        end
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    sequence s_stat_rd;
        regRead && regAddr == SDSP_OFF_STATUS;
    endsequence

    chk_rdata_idle_zero: assert property (!$past(regRead) |-> regRdata == 32'h0)
        else $error("read data not zero outside read answer");
    chk_status_upper_zero: assert property (s_stat_rd |=> regRdata[31:5] == 27'h0)
        else $error("status upper bits not zero");
    chk_busy_in_frame: assert property (
        (regRead && regAddr == SDSP_OFF_STATUS && !spiCsN) |=> regRdata[SDSP_ST_ACTIVE])
        else $error("active flag low during frame");
    chk_busy_tx_pending: assert property (s_stat_rd |=>
        (regRdata[SDSP_ST_TX_EMPTY] || regRdata[SDSP_ST_ACTIVE]))
        else $error("active flag low with transmit words pending");
    chk_tx_empty_space: assert property (s_stat_rd |=>
        (!regRdata[SDSP_ST_TX_EMPTY] || regRdata[SDSP_ST_TX_SPACE]))
        else $error("empty transmit fifo reported full");
    chk_rx_full_data: assert property (s_stat_rd |=>
        (!regRdata[SDSP_ST_RX_FULL] || regRdata[SDSP_ST_RX_DATA]))
        else $error("full receive fifo reported empty");
    chk_sclk_high_len: assert property ($fell(spiSclk) |-> highCnt == halfExp)
        else $error("serial clock high half has wrong length");
    chk_sclk_low_len: assert property ($rose(spiSclk) |-> lowCnt == halfExp)
        else $error("serial clock low half has wrong length");
    chk_sclk_idle_low: assert property (spiCsN |-> !spiSclk)
        else $error("serial clock toggles outside frame");
    chk_mosi_hold_high: assert property (spiSclk && $past(spiSclk) |-> $stable(spiMosi))
        else $error("serial data out moved while clock high");
endmodule

/* File: testbench/sdsp_peer.sv */
/*
 * Behavioural serial peer, clock mode 0, MSB first.
 * Assumes the core is master; answers a fresh word each frame.
 */
`timescale 1ns/1ps
module sdsp_peer (
    input wire logic spiSclk,
    input wire logic spiCsN,
    input wire logic spiMosi,
    output logic spiMiso,
    output logic [31:0] lastRx
);
    logic [31:0] txSh = 32'h0;
    logic [31:0] rxSh = 32'h0;
    int frameIdx = 0;

    initial begin
        spiMiso = 1'b0;
        lastRx = 32'h0;
    end

    always @(negedge spiCsN) begin
        txSh = 32'h9C3A5E71 + 32'(frameIdx) * 32'h01010101;
        frameIdx++;
        spiMiso <= txSh[31];
    end

    always @(posedge spiSclk) if (!spiCsN) rxSh = {rxSh[30:0], spiMosi};

    always @(negedge spiSclk) begin
        if (!spiCsN) begin
            txSh = txSh << 1;
            spiMiso <= txSh[31];
        end
    end

    // Released line shows no stale bit
    always @(posedge spiCsN) begin
        lastRx = rxSh;
        spiMiso <= ~spiMiso;
    end
endmodule

/* File: testbench/testbench.sv */
/*
 * Register-level test of the serial port core with a peer model.
 * Assumes FIFO depth 4; half periods suit the input filter except in the last case, which checks the delayed-input lag.
 */
`timescale 1ns/1ps
module testbench;
    import sdsp_pkg::*;
    localparam int DEPTH = 4;
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    logic [7:0] regAddr = 8'h00;
    logic [31:0] regWdata = 32'h0;
    logic regWrite = 1'b0;
    logic regRead = 1'b0;
    logic [31:0] regRdata;
    logic spiSclk;
    logic spiMosi;
    logic spiCsN;
    logic spiMiso;
    logic [31:0] peerRx;
    logic [31:0] rdVal;
    int error_cnt = 0;
    int checks_done = 0;
    int i;

    always #10 core_clk = ~core_clk;

    sdsp_core #(.FIFO_DEPTH(DEPTH)) i_dut (.core_clk(core_clk), .reset(reset),
        .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
        .regRdata(regRdata), .spiSclk(spiSclk), .spiMosi(spiMosi), .spiCsN(spiCsN),
        .spiMiso(spiMiso));
    sdsp_peer i_peer (.spiSclk(spiSclk), .spiCsN(spiCsN), .spiMosi(spiMosi),
        .spiMiso(spiMiso), .lastRx(peerRx));

    // ****************************************************************
    // Helpers
    // ****************************************************************
    function automatic logic [31:0] peerWord(input int n);
        return 32'h9C3A5E71 + 32'(n) * 32'h01010101;
    endfunction

    function automatic logic [31:0] txWord(input int n);
        return 32'hA5C30F00 ^ 32'(n);
    endfunction

    task automatic end_sim();
        $display("Checks %0d, errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH at %0t: got %h want %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        regWrite <= 1'b1;
        regAddr <= a;
        regWdata <= d;
        @(posedge core_clk);
        regWrite <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge core_clk);
        regRead <= 1'b1;
        regAddr <= a;
        @(posedge core_clk);
        regRead <= 1'b0;
        #1 d = regRdata;
    endtask

    task automatic rdChk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] v;
        rd(a, v);
        chk(v, exp);
    endtask

    // Polls status; a stuck port ends the run
    task automatic waitIdle();
        int n;
        n = 0;
        rd(SDSP_OFF_STATUS, rdVal);
        while (!(rdVal[SDSP_ST_TX_EMPTY] === 1'b1 && rdVal[SDSP_ST_ACTIVE] === 1'b0)) begin
            n++;
            if (n > 4000) begin
                error_cnt++;
                $display("MISMATCH at %0t: port never went idle", $time);
                end_sim();
            end
            rd(SDSP_OFF_STATUS, rdVal);
        end
    endtask

    // ****************************************************************
    // Sequence
    // ****************************************************************
    initial begin
        repeat (4) @(posedge core_clk);
        reset <= 1'b0;
        rdChk(SDSP_OFF_STATUS, 32'h03);
        rdChk(SDSP_OFF_PRESCALE, 32'h0);
        rdChk(SDSP_OFF_DATA, 32'h0);
        rdChk(8'h40, 32'h0);
        // Port disabled: fill transmit side, last word dropped
        for (i = 0; i < DEPTH + 1; i++) wr(SDSP_OFF_DATA, txWord(i));
        rdChk(SDSP_OFF_STATUS, 32'h10);
        wr(SDSP_OFF_PRESCALE, 32'h14);
        rdChk(SDSP_OFF_PRESCALE, 32'h14);
        wr(SDSP_OFF_CTRL0, 32'h1F);
        wr(SDSP_OFF_CTRL1, 32'h2);
        waitIdle();
        rdChk(SDSP_OFF_STATUS, 32'h0F);
        chk(peerRx, txWord(DEPTH - 1));
        // Receive side full: new word must wait
        wr(SDSP_OFF_DATA, txWord(9));
        rdChk(SDSP_OFF_STATUS, 32'h1E);
        for (i = 0; i < DEPTH; i++) rdChk(SDSP_OFF_DATA, peerWord(i));
        waitIdle();
        rdChk(SDSP_OFF_DATA, peerWord(DEPTH));
        rdChk(SDSP_OFF_DATA, peerWord(DEPTH));
        rdChk(SDSP_OFF_STATUS, 32'h03);
        chk(peerRx, txWord(9));
        // Short frame, input delay on, rate field above zero
        wr(SDSP_OFF_PRESCALE, 32'h08);
        wr(SDSP_OFF_CTRL0, 32'h0107);
        wr(SDSP_OFF_CTRL1, 32'h0020_0002);
        wr(SDSP_OFF_DATA, 32'hFFFF_FF5A);
        waitIdle();
        rdChk(SDSP_OFF_DATA, peerWord(DEPTH + 1) >> 24);
        chk({24'h0, peerRx[7:0]}, 32'h5A);
        // Half period of six: the delayed input lags one bit, so the first
        // bit taken is the idle level the peer left after the last frame
        wr(SDSP_OFF_PRESCALE, 32'h06);
        wr(SDSP_OFF_DATA, 32'h0000_00C3);
        waitIdle();
        rdVal = peerWord(DEPTH + 2);
        rdChk(SDSP_OFF_DATA, {24'h0, 1'b1, rdVal[31:25]});
        chk({24'h0, peerRx[7:0]}, 32'hC3);
        end_sim();
    end
endmodule

bind sdsp_core sdsp_core_monitor #(.FIFO_DEPTH(FIFO_DEPTH)) u_monitor (
    .core_clk(core_clk), .reset(reset), .regAddr(regAddr), .regWdata(regWdata),
    .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .spiSclk(spiSclk),
    .spiMosi(spiMosi), .spiCsN(spiCsN), .spiMiso(spiMiso));
